// *** dv/cxb_crossbar_sva.sv ***
// assertion checker for the port crossbar
`default_nettype none
`include "cxb_defs.vh"
module cxb_crossbar_sva (
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic [31:0] pin_skip,
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe_n,
  input wire logic [31:0] latch_out,
  input wire logic        serial0_tx,
  input wire logic        serial0_rx,
  input wire logic        ext_irq0_input_n,
  input wire logic        timer0_count_input,
  input wire logic        counter_ext_count_input
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  en0_q;
  logic [7:0]  en1_q;
  logic [31:0] skip_q;
  logic [2:0]  age_q;
  logic        glob_q;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  // shadow of the enables and cycles since the last change
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      en0_q <= 8'h00;
      en1_q <= 8'h00;
      glob_q <= 1'b0;
      skip_q <= 32'h0;
      age_q <= 3'h0;
    end else begin
      skip_q <= pin_skip;
      if (reg_wr && reg_addr == `CXB_ADDR_EN0) en0_q <= reg_wdata;
      if (reg_wr && reg_addr == `CXB_ADDR_EN1) en1_q <= reg_wdata;
      if (reg_wr && reg_addr == `CXB_ADDR_GLOBAL) glob_q <= reg_wdata[`CXB_GLOBAL_BIT];
      if (reg_wr || pin_skip != skip_q) age_q <= 3'h0;
      else if (age_q != 3'h7) age_q <= age_q + 3'h1;
    end
  end
  sequence s_rd0;
    reg_rd && reg_addr == `CXB_ADDR_EN0;
  endsequence
  property p_rd0;
    s_rd0 |=> reg_rdata == $past(en0_q);
  endproperty
  a_rd0: assert property (p_rd0) else $error("enable0 read data wrong");
  property p_rd1;
    reg_rd && reg_addr == `CXB_ADDR_EN1 |=> reg_rdata == $past(en1_q);
  endproperty
  a_rd1: assert property (p_rd1) else $error("enable1 read data wrong");
  property p_off;
    !glob_q && age_q > 3'h1 |-> pin_oe_n == '1;
  endproperty
  a_off: assert property (p_off) else $error("pin driven while crossbar off");
  property p_latch;
    en0_q == 8'h00 && en1_q == 8'h00 && age_q > 3'h1 |-> pin_out == latch_out;
  endproperty
  a_latch: assert property (p_latch) else $error("free pin not from latch");
  property p_uart;
    glob_q && en0_q[2] && skip_q == 32'h0 && age_q > 3'h1 |-> !pin_oe_n[0] && pin_out[0] == serial0_tx;
  endproperty
  a_uart: assert property (p_uart) else $error("serial transmit not on pin 0");
  property p_idle;
    !glob_q && age_q > 3'h5 |-> serial0_rx && ext_irq0_input_n;
  endproperty
  a_idle: assert property (p_idle) else $error("input not idle while off");
  property p_t0;
    !en1_q[1] && age_q > 3'h5 |-> !timer0_count_input;
  endproperty
  a_t0: assert property (p_t0) else $error("timer0 input not idle");
  property p_eci;
    !en0_q[6] && age_q > 3'h5 |-> !counter_ext_count_input;
  endproperty
  a_eci: assert property (p_eci) else $error("counter input not idle");
endmodule
bind cxb_crossbar cxb_crossbar_sva i_cxb_crossbar_sva (
  .clock, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pin_skip,
  .pin_out, .pin_oe_n, .latch_out, .serial0_tx, .serial0_rx, .ext_irq0_input_n,
  .timer0_count_input, .counter_ext_count_input
);
`default_nettype wire

// *** dv/cxb_crossbar_test.sv ***
// self-checking bench for the port crossbar
`default_nettype none
`include "cxb_defs.vh"
module cxb_crossbar_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, resetn, reg_wr, reg_rd;
  logic [7:0]  reg_addr, reg_wdata;
  wire  [7:0]  reg_rdata;
  logic [31:0] pin_skip, latch_out, latch_oe_n, ext_val, ext_en;
  wire  [31:0] pin_in, pin_out, pin_oe_n;
  logic [10:0] drv;
  logic [4:0]  cm_out, cm_oe_n;
  wire         serial0_rx, ext_irq0_input_n;
  int          n_mismatch, num_checks;
  cxb_crossbar i_cxb_crossbar (
    .clock, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .pin_skip, .pin_in, .pin_out, .pin_oe_n, .latch_out, .latch_oe_n,
    .serial0_tx(drv[0]), .serial0_rx, .spi_sck_out(drv[1]), .spi_sck_oe_n(drv[2]),
    .spi_miso_out(drv[3]), .spi_miso_oe_n(drv[4]), .spi_mosi_out(drv[5]),
    .spi_mosi_oe_n(drv[6]), .spi_sck_in(), .spi_miso_in(), .spi_mosi_in(),
    .spi_nss_in(), .smbus_sda_out(drv[7]), .smbus_scl_out(drv[8]), .smbus_sda_in(),
    .smbus_scl_in(), .counter_module_io_out(cm_out), .counter_module_io_oe_n(cm_oe_n),
    .counter_module_io_in(), .counter_ext_count_input(), .comparator0_output(drv[9]),
    .comparator1_output(drv[10]), .timer0_count_input(), .ext_irq0_input_n,
    .timer1_count_input(), .ext_irq1_input_n(), .timer2_count_input(), .timer2_capture_input()
  );
  cxb_pins_model i_cxb_pins_model (.pin_out, .pin_oe_n, .ext_val, .ext_en, .pin_in);
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
    @(posedge clock);
  endtask
  task automatic cnt(input logic [7:0] e0, input logic [7:0] e1, input logic [7:0] n);
    wr(`CXB_ADDR_EN0, e0);
    wr(`CXB_ADDR_EN1, e1);
    rd(`CXB_ADDR_EN0, e0);
    rd(`CXB_ADDR_EN1, e1);
    rd(`CXB_ADDR_STATUS, n);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    end_of_test();
  end
  initial begin
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    drv = 11'h000;
    cm_out = 5'h00;
    cm_oe_n = 5'h00;
    pin_skip = 32'h0;
    latch_out = 32'hA5A55A5A;
    latch_oe_n = '1;
    ext_val = '1;
    ext_en = '0;
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    rd(`CXB_ADDR_EN0, 8'h00);
    rd(`CXB_ADDR_EN1, 8'h00);
    chk(pin_oe_n, '1);
    $display("test reset done");
    cnt(8'h80, 8'h00, 8'h01);
    cnt(8'h40, 8'h00, 8'h01);
    for (int k = 0; k < 6; k++) begin // counts below 110
      cnt(8'(k * 8), 8'h00, 8'(k));
    end
    cnt(8'h04, 8'h00, 8'h02);
    cnt(8'h02, 8'h00, 8'h04);
    cnt(8'h01, 8'h00, 8'h02);
    for (int b = 0; b < 8; b++) begin
      cnt(8'h00, 8'(1 << b), 8'h01);
    end
    cnt(8'hEF, 8'hFF, 8'h17);
    $display("test counts done");
    wr(`CXB_ADDR_EN0, 8'h04);
    wr(`CXB_ADDR_GLOBAL, 8'h40);
    drv[0] <= 1'b1;
    ext_en[1] <= 1'b1;
    ext_val[1] <= 1'b0;
    repeat (6) @(posedge clock);
    #1;
    chk(pin_oe_n[1:0], 2'b10);
    chk(pin_out[0], 1'b1);
    chk(serial0_rx, 1'b0);
    pin_skip[0] <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    chk(pin_oe_n[2:0], 3'b101);
    chk(pin_out[1:0], 2'b10);
    pin_skip <= 32'h0;
    wr(`CXB_ADDR_EN1, 8'h00);
    wr(`CXB_ADDR_EN0, 8'h2F);
    repeat (2) @(posedge clock);
    #1;
    chk(pin_oe_n[13:8], 6'b100000);
    wr(`CXB_ADDR_P1MODE, 8'hFE);
    repeat (2) @(posedge clock);
    #1;
    chk(pin_oe_n[13:8], 6'b000001);
    wr(`CXB_ADDR_GLOBAL, 8'h00);
    repeat (6) @(posedge clock);
    #1;
    chk(pin_oe_n, '1);
    chk(serial0_rx, 1'b1);
    chk(ext_irq0_input_n, 1'b1);
    $display("test routing done");
    end_of_test();
  end
endmodule
`default_nettype wire

// *** dv/cxb_pins_model.sv ***
// pin-side model: pins loop back, released pins pulled up
`default_nettype none
module cxb_pins_model (
  input  wire logic [31:0] pin_out,
  input  wire logic [31:0] pin_oe_n,
  input  wire logic [31:0] ext_val,
  input  wire logic [31:0] ext_en,
  output wire logic [31:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // device drive wins, else outside drive, else pull-up
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val) | (pin_oe_n & ~ext_en);
endmodule
`default_nettype wire

// *** src/cxb_crossbar.v ***
// port crossbar: peripheral enables and priority pin assignment
//
// Overview of operation
// - enable0 bit7 routes comparator0 output
// - enable0 bit6 routes counter external input
// - bits5-3 route counter module I/Os cumulatively
// - enable0 bit2 routes serial0 to the first two non-skipped pins
// - enable0 bit1 routes four SPI signals
// - enable0 bit0 routes SMBus data and clock
// - enable1 bit7 drives inverted clock out
// - enable1 bit6 routes timer2 capture input
// - enable1 bit5 routes timer2 count input
// - enable1 bit4 routes external irq1 input
// - enable1 bit3 routes timer1 count input
// - enable1 bit2 routes external irq0 input
// - enable1 bit1 routes timer0 count input
// - enable1 bit0 routes comparator1 output
// - priority order, skipped pins passed over
// - analog port1 pins skipped by crossbar
// - global enable clear forces all pins input
`default_nettype none
`include "cxb_defs.vh"
module cxb_crossbar (
  input  wire        clock,
  input  wire        resetn,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  input  wire [31:0] pin_skip,
  input  wire [31:0] pin_in,
  output reg  [31:0] pin_out,
  output reg  [31:0] pin_oe_n,
  input  wire [31:0] latch_out,
  input  wire [31:0] latch_oe_n,
  input  wire        serial0_tx,
  output wire        serial0_rx,
  input  wire        spi_sck_out,
  input  wire        spi_sck_oe_n,
  input  wire        spi_miso_out,
  input  wire        spi_miso_oe_n,
  input  wire        spi_mosi_out,
  input  wire        spi_mosi_oe_n,
  output wire        spi_sck_in,
  output wire        spi_miso_in,
  output wire        spi_mosi_in,
  output wire        spi_nss_in,
  input  wire        smbus_sda_out,
  input  wire        smbus_scl_out,
  output wire        smbus_sda_in,
  output wire        smbus_scl_in,
  input  wire [4:0]  counter_module_io_out,
  input  wire [4:0]  counter_module_io_oe_n,
  output wire [4:0]  counter_module_io_in,
  output wire        counter_ext_count_input,
  input  wire        comparator0_output,
  input  wire        comparator1_output,
  output wire        timer0_count_input,
  output wire        ext_irq0_input_n,
  output wire        timer1_count_input,
  output wire        ext_irq1_input_n,
  output wire        timer2_count_input,
  output wire        timer2_capture_input
);
  reg  [7:0]   en0_q;
  reg  [7:0]   en1_q;
  reg          global_q;
  reg  [7:0]   p1mode_q;
  reg  [159:0] owner_q;
  reg  [159:0] owner_d;
  reg  [31:0]  used_q;
  reg  [31:0]  used_d;
  reg  [5:0]   count_q;
  reg  [5:0]   count_d;
  reg  [22:0]  sig_in_q;
  reg  [22:0]  sig_in_d;
  reg  [22:0]  sig_en;
  reg  [22:0]  sig_out;
  reg  [22:0]  sig_oe_n;
  reg  [31:0]  skip;
  reg  [5:0]   cur;
  reg  [4:0]   sv;
  reg  [4:0]   own;
  reg          found;
  reg  [2:0]   cex_n;
  wire [31:0]  pin_s;
  integer      p;
  integer      s;
  integer      s_en;
  integer      s_in;
  integer      p_in;
  integer      p_drv;

  cxb_sync #(
    .W(32)
  ) u_sync (
    .clock  (clock),
    .resetn (resetn),
    .d      (pin_in),
    .q      (pin_s)
  );

  // register writes
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      en0_q    <= `CXB_RST_EN0;
      en1_q    <= `CXB_RST_EN1;
      global_q <= `CXB_RST_GLOBAL;
      p1mode_q <= `CXB_RST_P1MODE;
    end else if (reg_wr) begin
      case (reg_addr)
        `CXB_ADDR_EN0: en0_q <= reg_wdata;
        `CXB_ADDR_EN1: en1_q <= reg_wdata;
        `CXB_ADDR_GLOBAL: global_q <= reg_wdata[`CXB_GLOBAL_BIT];
        `CXB_ADDR_P1MODE: p1mode_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // register reads, data in the next cycle
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `CXB_ADDR_EN0: reg_rdata <= en0_q;
        `CXB_ADDR_EN1: reg_rdata <= en1_q;
        `CXB_ADDR_GLOBAL: reg_rdata <= {1'b0, global_q, 6'h00};
        `CXB_ADDR_P1MODE: reg_rdata <= p1mode_q;
        `CXB_ADDR_STATUS: reg_rdata <= {2'h0, count_q};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // per-signal enables, outputs and drive enables
  always @* begin
    cex_n = en0_q[`CXB_EN0_CNT_HI:`CXB_EN0_CNT_LO];
    sig_en = 23'h000000;
    sig_en[`CXB_S_TX0]  = en0_q[`CXB_EN0_UART];
    sig_en[`CXB_S_RX0]  = en0_q[`CXB_EN0_UART];
    sig_en[`CXB_S_SCK]  = en0_q[`CXB_EN0_SPI];
    sig_en[`CXB_S_MISO] = en0_q[`CXB_EN0_SPI];
    sig_en[`CXB_S_MOSI] = en0_q[`CXB_EN0_SPI];
    sig_en[`CXB_S_NSS]  = en0_q[`CXB_EN0_SPI];
    sig_en[`CXB_S_SDA]  = en0_q[`CXB_EN0_SMB];
    sig_en[`CXB_S_SCL]  = en0_q[`CXB_EN0_SMB];
    for (s_en = 0; s_en < 5; s_en = s_en + 1) begin
      // codes above 101 are reserved; they route none here
      sig_en[`CXB_S_COUNTER_MODULE_A_IO + s_en] = (cex_n <= 3'h5) && (s_en < cex_n);
    end
    sig_en[`CXB_S_ECI]  = en0_q[`CXB_EN0_ECI];
    sig_en[`CXB_S_CP0]  = en0_q[`CXB_EN0_CP0];
    sig_en[`CXB_S_CP1]  = en1_q[`CXB_EN1_CP1];
    sig_en[`CXB_S_T0]   = en1_q[`CXB_EN1_T0];
    sig_en[`CXB_S_EXT_IRQ0_INPUT] = en1_q[`CXB_EN1_EXT_IRQ0_INPUT];
    sig_en[`CXB_S_T1]   = en1_q[`CXB_EN1_T1];
    sig_en[`CXB_S_EXT_IRQ1_INPUT] = en1_q[`CXB_EN1_EXT_IRQ1_INPUT];
    sig_en[`CXB_S_T2]   = en1_q[`CXB_EN1_T2];
    sig_en[`CXB_S_TIMER2_CAPTURE_INPUT] = en1_q[`CXB_EN1_TIMER2_CAPTURE_INPUT];
    sig_en[`CXB_S_CLK]  = en1_q[`CXB_EN1_CLK];

    sig_out  = 23'h000000;
    sig_oe_n = {23{1'b1}};
    sig_out[`CXB_S_TX0]   = serial0_tx;
    sig_oe_n[`CXB_S_TX0]  = 1'b0;
    sig_out[`CXB_S_SCK]   = spi_sck_out;
    sig_oe_n[`CXB_S_SCK]  = spi_sck_oe_n;
    sig_out[`CXB_S_MISO]  = spi_miso_out;
    sig_oe_n[`CXB_S_MISO] = spi_miso_oe_n;
    sig_out[`CXB_S_MOSI]  = spi_mosi_out;
    sig_oe_n[`CXB_S_MOSI] = spi_mosi_oe_n;
    // open-drain: pull low only
    sig_oe_n[`CXB_S_SDA]  = smbus_sda_out;
    sig_oe_n[`CXB_S_SCL]  = smbus_scl_out;
    for (s_en = 0; s_en < 5; s_en = s_en + 1) begin
      sig_out[`CXB_S_COUNTER_MODULE_A_IO + s_en]  = counter_module_io_out[s_en];
      sig_oe_n[`CXB_S_COUNTER_MODULE_A_IO + s_en] = counter_module_io_oe_n[s_en];
    end
    sig_out[`CXB_S_CP0]  = comparator0_output;
    sig_oe_n[`CXB_S_CP0] = 1'b0;
    sig_out[`CXB_S_CP1]  = comparator1_output;
    sig_oe_n[`CXB_S_CP1] = 1'b0;
    sig_out[`CXB_S_CLK]  = ~clock;
    sig_oe_n[`CXB_S_CLK] = 1'b0;
  end

  // priority assignment over non-skipped pins
  always @* begin
    found = 1'b0;
    sv = 5'h00;
    skip = pin_skip;
    for (p = 0; p < 8; p = p + 1) begin
      if (!p1mode_q[p]) begin
        skip[`CXB_P1_LO + p] = 1'b1;
      end
    end
    cur = 6'h00;
    count_d = 6'h00;
    owner_d = {160{1'b1}};
    used_d = 32'h00000000;
    for (p = 0; p < `CXB_NPIN; p = p + 1) begin
      found = 1'b0;
      if (!skip[p]) begin
        for (s = 0; s < `CXB_NSIG; s = s + 1) begin
          sv = s[4:0];
          if (!found && ({1'b0, sv} >= cur) && sig_en[s]) begin
            found = 1'b1;
            owner_d[p*5 +: 5] = sv;
            used_d[p] = 1'b1;
            cur = {1'b0, sv} + 6'h01;
            count_d = count_d + 6'h01;
          end
        end
      end
    end
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      owner_q <= {160{1'b1}};
      used_q  <= 32'h00000000;
      count_q <= 6'h00;
    end else begin
      owner_q <= owner_d;
      used_q  <= used_d;
      count_q <= count_d;
    end
  end

  // peripheral inputs from their assigned pins
  always @* begin
    sig_in_d = `CXB_SIG_IDLE;
    for (s_in = 0; s_in < `CXB_NSIG; s_in = s_in + 1) begin
      for (p_in = 0; p_in < `CXB_NPIN; p_in = p_in + 1) begin
        if (global_q && used_q[p_in] && owner_q[p_in*5 +: 5] == s_in[4:0]) begin
          sig_in_d[s_in] = pin_s[p_in];
        end
      end
    end
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sig_in_q <= `CXB_SIG_IDLE;
    end else begin
      sig_in_q <= sig_in_d;
    end
  end

  assign serial0_rx              = sig_in_q[`CXB_S_RX0];
  assign spi_sck_in              = sig_in_q[`CXB_S_SCK];
  assign spi_miso_in             = sig_in_q[`CXB_S_MISO];
  assign spi_mosi_in             = sig_in_q[`CXB_S_MOSI];
  assign spi_nss_in              = sig_in_q[`CXB_S_NSS];
  assign smbus_sda_in            = sig_in_q[`CXB_S_SDA];
  assign smbus_scl_in            = sig_in_q[`CXB_S_SCL];
  assign counter_module_io_in    = sig_in_q[`CXB_S_COUNTER_MODULE_A_IO +: 5];
  assign counter_ext_count_input = sig_in_q[`CXB_S_ECI];
  assign timer0_count_input      = sig_in_q[`CXB_S_T0];
  assign ext_irq0_input_n        = sig_in_q[`CXB_S_EXT_IRQ0_INPUT];
  assign timer1_count_input      = sig_in_q[`CXB_S_T1];
  assign ext_irq1_input_n        = sig_in_q[`CXB_S_EXT_IRQ1_INPUT];
  assign timer2_count_input      = sig_in_q[`CXB_S_T2];
  assign timer2_capture_input    = sig_in_q[`CXB_S_TIMER2_CAPTURE_INPUT];

  // pin drive
  always @* begin
    own = 5'h1F;
    for (p_drv = 0; p_drv < `CXB_NPIN; p_drv = p_drv + 1) begin
      own = owner_q[p_drv*5 +: 5];
      if (!global_q) begin
        pin_out[p_drv]  = latch_out[p_drv];
        pin_oe_n[p_drv] = 1'b1;
      end else if (used_q[p_drv] && own < 5'h17) begin
        pin_out[p_drv]  = sig_out[own];
        pin_oe_n[p_drv] = sig_oe_n[own];
      end else begin
        pin_out[p_drv]  = latch_out[p_drv];
        pin_oe_n[p_drv] = latch_oe_n[p_drv];
      end
    end
  end
endmodule
`default_nettype wire

// *** src/cxb_defs.vh ***
// crossbar register map, field positions and signal order
`ifndef CXB_DEFS_VH
`define CXB_DEFS_VH

`define CXB_ADDR_EN0       8'hE1
`define CXB_ADDR_EN1       8'hE2
`define CXB_ADDR_GLOBAL    8'hE3
`define CXB_ADDR_P1MODE    8'hBD
`define CXB_ADDR_STATUS    8'hE4

`define CXB_RST_EN0        8'h00
`define CXB_RST_EN1        8'h00
`define CXB_RST_GLOBAL     1'b0
`define CXB_RST_P1MODE     8'hFF

`define CXB_EN0_CP0        7
`define CXB_EN0_ECI        6
`define CXB_EN0_CNT_HI     5
`define CXB_EN0_CNT_LO     3
`define CXB_EN0_UART       2
`define CXB_EN0_SPI        1
`define CXB_EN0_SMB        0

`define CXB_EN1_CLK        7
`define CXB_EN1_TIMER2_CAPTURE_INPUT       6
`define CXB_EN1_T2         5
`define CXB_EN1_EXT_IRQ1_INPUT       4
`define CXB_EN1_T1         3
`define CXB_EN1_EXT_IRQ0_INPUT       2
`define CXB_EN1_T0         1
`define CXB_EN1_CP1        0

`define CXB_GLOBAL_BIT     6

// peripheral signals in priority order
`define CXB_S_TX0          0
`define CXB_S_RX0          1
`define CXB_S_SCK          2
`define CXB_S_MISO         3
`define CXB_S_MOSI         4
`define CXB_S_NSS          5
`define CXB_S_SDA          6
`define CXB_S_SCL          7
`define CXB_S_COUNTER_MODULE_A_IO         8
`define CXB_S_ECI          13
`define CXB_S_CP0          14
`define CXB_S_CP1          15
`define CXB_S_T0           16
`define CXB_S_EXT_IRQ0_INPUT         17
`define CXB_S_T1           18
`define CXB_S_EXT_IRQ1_INPUT         19
`define CXB_S_T2           20
`define CXB_S_TIMER2_CAPTURE_INPUT         21
`define CXB_S_CLK          22
`define CXB_NSIG           23
`define CXB_NPIN           32
`define CXB_P1_LO          8

// idle level seen by a peripheral input with no pin
`define CXB_SIG_IDLE       23'h0A00E2

`endif

// *** src/cxb_sync.v ***
// two-stage synchroniser for pin inputs
`default_nettype none
module cxb_sync #(
  parameter W = 32
) (
  input  wire         clock,
  input  wire         resetn,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta_q;

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      meta_q <= {W{1'b1}};
      q      <= {W{1'b1}};
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire
